// ==== i3c_async0_timing_control.sv ====
/*
  Asynchronous timing control, mode 0, for the target side of an I3C link.
  Counts internal oscillator rising edges from data ready to interrupt acknowledge,
  and from acknowledge to the transition bit of the mandatory byte, then
  offers both counts as payload bytes of the same in-band interrupt.
  Assumes a target protocol engine on ref_clk that decodes commands, runs
  the interrupt on the bus and pulls payload bytes; dataReady comes from the
  measurement logic on ref_clk; oscIn is the free-running oscillator.
*/
`include "timing_ctrl_defines.svh"

// Overview of operation
// R1: Only asynchronous mode 0 is implemented; other timing sub-commands leave it.
// R2: All counts are in ticks of the internal oscillator, sampled as edges.
// R3: First count runs from data ready to interrupt acknowledge.
// R4: Second count runs from acknowledge to the mandatory byte transition bit.
// R5: Capability query answers accuracy, frequency in 500 kHz units, async0 and sync.
// R6: Set command with sub-command 0xDF enters asynchronous mode 0.
// R7: In mode 0 data ready raises interrupts without a separate enable.
// R8: Each timed event is one in-band interrupt carrying its counts.
// R9: Controller may stall the clock briefly during the mandatory byte read.
// R10: Both counts are latched at their ends and sent after the mandatory byte.
module i3c_async0_timing_control
(
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic                        oscIn,
  input  wire timing_ctrl_pkg::ccc_t       ccc,
  input  wire logic                        dataReady,
  input  wire logic                        ibiAck,
  input  wire logic                        transitionBit,
  input  wire logic                        payloadTake,
  output timing_ctrl_pkg::xtime_reply_t    reply,
  output logic                             replyValid,
  output logic                             async0Active,
  output logic                             ibiRequest,
  output timing_ctrl_pkg::payload_t        payload
);

  import timing_ctrl_pkg::*;

  typedef enum logic [1:0] {
    ST_ARMED,
    ST_COUNT1,
    ST_COUNT2,
    ST_PAYLOAD
  } phase_t;

  phase_t                   phase_q;
  phase_t                   phase_d;
  logic                     mode_q;
  logic                     mode_d;
  logic [`COUNT_W-1:0]      count_q;
  logic [`COUNT_W-1:0]      count_d;
  logic [`COUNT_W-1:0]      first_q;
  logic [`COUNT_W-1:0]      second_q;
  logic [`BYTE_IDX_W-1:0]   byteIdx_q;
  logic [`BYTE_IDX_W-1:0]   byteIdx_d;
  logic                     ibi_q;
  xtime_reply_t             reply_q;
  logic                     replyValid_q;
  payload_t                 payload_q;
  payload_t                 payload_d;
  logic                     oscTick;

  wire                      enterAsync0;
  wire                      leaveAsync0;
  wire                      startEvent;
  wire                      ackEvent;
  wire                      tbitEvent;
  wire                      byteTaken;
  wire                      lastTaken;
  wire                      countSat;
  wire [`COUNT_W-1:0]       countInc;
  wire [7:0]                byteSel;
  wire [2*`COUNT_W-1:0]     countBytes;
  wire [7:0]                stateByte;
  wire [7:0]                modesByte;

  // Rising oscillator edges become one-cycle ticks on ref_clk.
  osc_edge_detect u_osc_edge
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .oscIn   (oscIn),
    .tick    (oscTick)
  );

  // Mode switching: 0xDF enters mode 0, any other timing sub-command leaves it.
  assign enterAsync0 = ccc.setTime & (ccc.subCmd == `SUBCMD_ASYNC0); // R6
  assign leaveAsync0 = ccc.setTime & (ccc.subCmd != `SUBCMD_ASYNC0); // R1
  assign mode_d      = enterAsync0 ? 1'b1 : (leaveAsync0 ? 1'b0 : mode_q);

  // Sequence events; data ready needs the mode and the armed phase, no interrupt enable.
  assign startEvent = mode_q & dataReady & (phase_q == ST_ARMED); // R7
  assign ackEvent   = ibiAck & (phase_q == ST_COUNT1);            // R3
  assign tbitEvent  = transitionBit & (phase_q == ST_COUNT2);     // R4
  assign byteTaken  = payloadTake & payload_q.valid;
  assign lastTaken  = byteTaken & payload_q.last;

  // Oscillator tick counter saturates rather than wrapping on long waits.
  assign countSat = (count_q == `COUNT_MAX);
  assign countInc = countSat ? count_q : count_q + `COUNT_W'(1);

  // Payload order: first count low, first high, second low, second high.
  assign countBytes = {second_q, first_q};
  assign byteSel    = countBytes[byteIdx_d*8 +: 8]; // R10

  // Capability reply fields.
  assign modesByte = 8'(1 << `MODE_BIT_SYNC) | 8'(1 << `MODE_BIT_ASYNC0); // R5
  assign stateByte = mode_q ? 8'(1 << `STATE_BIT_ASYNC0) : 8'h00;

  // Phase sequencing; leaving the mode abandons any sequence in flight.
  always_comb
  begin
    phase_d = phase_q;
    count_d = count_q;
    if (leaveAsync0)
    begin
      phase_d = ST_ARMED;
    end
    else
    begin
      unique case (phase_q)
        ST_ARMED:
        begin
          if (startEvent)
          begin
            phase_d = ST_COUNT1;
            count_d = '0; // R3
          end
        end
        ST_COUNT1:
        begin
          if (ackEvent)
          begin
            phase_d = ST_COUNT2;
            // A tick on the acknowledge edge belongs to the first count only.
            count_d = '0; // R4
          end
          else if (oscTick)
          begin
            count_d = countInc; // R2
          end
        end
        ST_COUNT2:
        begin
          if (tbitEvent)
          begin
            phase_d = ST_PAYLOAD;
          end
          else if (oscTick)
          begin
            count_d = countInc; // R2
          end
        end
        ST_PAYLOAD:
        begin
          if (lastTaken)
          begin
            phase_d = ST_ARMED;
          end
        end
      endcase
    end
  end

  // Payload byte pointer and the byte offered next.
  always_comb
  begin
    byteIdx_d = byteIdx_q;
    payload_d = payload_q;
    if (leaveAsync0 || lastTaken)
    begin
      byteIdx_d = '0;
      payload_d = '0;
    end
    else if (tbitEvent)
    begin
      byteIdx_d       = '0;
      payload_d.valid = 1'b1;
      payload_d.last  = 1'b0;
    end
    else if (byteTaken)
    begin
      byteIdx_d       = byteIdx_q + `BYTE_IDX_W'(1);
      payload_d.last  = (byteIdx_d == `BYTE_IDX_W'(`PAYLOAD_BYTES - 1));
    end
    payload_d.data = payload_d.valid ? byteSel : 8'h00;
  end

  // Mode, phase and counter state.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_q  <= 1'b0;
      phase_q <= ST_ARMED;
      count_q <= '0;
    end
    else
    begin
      mode_q  <= mode_d;
      phase_q <= phase_d;
      count_q <= count_d;
    end
  end

  // Count latches: each count is frozen at its own ending event.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      first_q  <= '0;
      second_q <= '0;
    end
    else
    begin
      if (ackEvent)
        first_q <= oscTick ? countInc : count_q; // R10
      if (tbitEvent)
        second_q <= oscTick ? countInc : count_q; // R10
    end
  end

  // Interrupt request stands from data ready until the acknowledge.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ibi_q <= 1'b0;
    else if (startEvent && !leaveAsync0)
      ibi_q <= 1'b1; // R8
    else if (ackEvent || leaveAsync0)
      ibi_q <= 1'b0;
  end

  // Payload pointer and offered byte.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      byteIdx_q <= '0;
      payload_q <= '0;
    end
    else
    begin
      byteIdx_q <= byteIdx_d;
      payload_q <= payload_d;
    end
  end

  // Capability reply is presented one cycle after the query, for one cycle.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reply_q      <= '0;
      replyValid_q <= 1'b0;
    end
    else
    begin
      replyValid_q <= ccc.getTime; // R5
      if (ccc.getTime)
      begin
        reply_q.modes    <= modesByte;
        reply_q.state    <= stateByte;
        reply_q.freq     <= 8'(`OSC_FREQ_CODE);
        reply_q.accuracy <= 8'(`OSC_ACCURACY_PCT);
      end
    end
  end

  // Outputs come straight from registers.
  assign reply        = reply_q;
  assign replyValid   = replyValid_q;
  assign async0Active = mode_q;
  assign ibiRequest   = ibi_q;
  assign payload      = payload_q;

endmodule

// ==== timing_ctrl_defines.svh ====
/*
  Constants for the asynchronous timing control block: oscillator figures,
  capability reply encodings and counter widths.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TIMING_CTRL_DEFINES_SVH
`define TIMING_CTRL_DEFINES_SVH

// Internal oscillator nominal rate in Hz and the reporting unit in Hz.
`define OSC_FREQ_HZ        4320000
`define OSC_FREQ_UNIT_HZ   500000
// Frequency byte, rounded to the nearest multiple of the unit.
`define OSC_FREQ_CODE      ((`OSC_FREQ_HZ + (`OSC_FREQ_UNIT_HZ / 2)) / `OSC_FREQ_UNIT_HZ)
// Oscillator accuracy in whole percent.
`define OSC_ACCURACY_PCT   5

// Sub-command byte that enters asynchronous mode 0.
`define SUBCMD_ASYNC0      8'hDF

// Supported-modes byte of the capability reply.
`define MODE_BIT_SYNC      0
`define MODE_BIT_ASYNC0    1
// State byte of the capability reply.
`define STATE_BIT_ASYNC0   1

// Width of each timing count and number of payload bytes after the mandatory byte.
`define COUNT_W            16
`define COUNT_MAX          16'hFFFF
`define PAYLOAD_BYTES      4
`define BYTE_IDX_W         2

`endif

// ==== timing_ctrl_pkg.sv ====
/*
  Types shared by the asynchronous timing control block and its bench.
  Assumes the defines header sits in the same folder.
*/
`include "timing_ctrl_defines.svh"

package timing_ctrl_pkg;

  // Decoded common command from the target protocol engine, valid for one cycle.
  typedef struct packed {
    logic       getTime;
    logic       setTime;
    logic [7:0] subCmd;
  } ccc_t;

  // Capability reply, four bytes handed back as one word.
  typedef struct packed {
    logic [7:0] modes;
    logic [7:0] state;
    logic [7:0] freq;
    logic [7:0] accuracy;
  } xtime_reply_t;

  // One payload byte offered to the protocol engine.
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } payload_t;

endpackage

// ==== osc_edge_detect.sv ====
/*
  Synchroniser and rising edge detector for the internal oscillator clock.
  Assumes oscIn is asynchronous to refClk and slower than half its rate.
*/
module osc_edge_detect
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic oscIn,
  output logic      tick
);

  logic syncA_q;
  logic syncB_q;
  logic prev_q;
  logic tick_q;
  wire  riseSeen;

  // The edge is judged only on the second stage and its delayed copy.
  assign riseSeen = syncB_q & ~prev_q;

  // Two-stage synchroniser, a history stage and the registered pulse.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      prev_q  <= 1'b0;
      tick_q  <= 1'b0;
    end
    else
    begin
      syncA_q <= oscIn;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
      tick_q  <= riseSeen;
    end
  end

  assign tick = tick_q;

endmodule

// ==== timing_ctrl_checker.sv ====
/* Port checker for the timing control block.
   Assumes it is bound onto the block's top module. */
module timing_ctrl_checker
  import timing_ctrl_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         resetn,
  input wire ccc_t         ccc,
  input wire logic         dataReady,
  input wire logic         ibiAck,
  input wire logic         payloadTake,
  input wire xtime_reply_t reply,
  input wire logic         replyValid,
  input wire logic         async0Active,
  input wire logic         ibiRequest,
  input wire payload_t     payload
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Ties replies, mode, interrupts and payload to their causes.
  reply_follow_a: assert property (ccc.getTime |=> replyValid &&
    reply.modes[1:0] == 2'b11 && reply.freq == 8'h09 && reply.accuracy == 8'h05)
    else $error("reply wrong after query");
  reply_cause_a: assert property (replyValid |-> $past(ccc.getTime))
    else $error("reply without query");
  mode_enter_a: assert property (ccc.setTime && ccc.subCmd == 8'hDF |=> async0Active)
    else $error("mode not entered");
  mode_leave_a: assert property (ccc.setTime && ccc.subCmd != 8'hDF |=> !async0Active)
    else $error("mode not left");
  mode_hold_a: assert property (!ccc.setTime |=> $stable(async0Active))
    else $error("mode changed without command");
  ibi_start_a: assert property ($rose(ibiRequest) |->
    $past(dataReady) && $past(async0Active)) else $error("interrupt without cause");
  ibi_ack_a: assert property (ibiRequest && ibiAck |=> !ibiRequest)
    else $error("interrupt held after acknowledge");
  pay_wait_a: assert property (ibiRequest |-> !payload.valid)
    else $error("payload before acknowledge");
  pay_end_a: assert property (payload.valid && payload.last && payloadTake
    |=> !payload.valid) else $error("payload after last byte");
  cover property (replyValid);
  cover property (ibiRequest && ibiAck);
  cover property (payload.last && payloadTake);
endmodule

bind i3c_async0_timing_control timing_ctrl_checker u_chk (.ref_clk, .resetn, .ccc,
  .dataReady, .ibiAck, .payloadTake, .reply, .replyValid, .async0Active, .ibiRequest,
  .payload);

// ==== ibi_ctrl_model.sv ====
/* Bus controller model: acknowledges interrupts, marks the transition bit
   and takes payload bytes with random stalls.
   Assumes the block's ports on ref_clk; drives at the falling edge. */
module ibi_ctrl_model
  import timing_ctrl_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     ibiRequest,
  input  wire payload_t payload,
  output logic          ibiAck,
  output logic          transitionBit,
  output logic          payloadTake
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h0000_b546;
  int w;

  // Acknowledge after a random wait, then stall before the transition bit.
  initial
  begin
    ibiAck = 1'b0;
    transitionBit = 1'b0;
    forever
    begin
      @(negedge ref_clk);
      if (ibiRequest)
      begin
        w = 2 + {$random(seed)} % 40;
        repeat (w) @(negedge ref_clk);
        ibiAck = ibiRequest;
        @(negedge ref_clk);
        ibiAck = 1'b0;
        w = 1 + {$random(seed)} % 20;
        repeat (w) @(negedge ref_clk);
        transitionBit = 1'b1;
        @(negedge ref_clk);
        transitionBit = 1'b0;
      end
    end
  end

  // Takes offered bytes, skipping a cycle now and then.
  initial payloadTake = 1'b0;
  always @(negedge ref_clk)
    payloadTake = payload.valid && ({$random(seed)} % 3 != 0);
endmodule

// ==== tb_i3c_async0_timing_control.sv ====
/* Bench for the timing control block: queries, mode changes, timed events.
   Assumes the controller model and the checker are compiled first. */
module tb_i3c_async0_timing_control;
  import timing_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk = 1'b0;
  logic         resetn = 1'b0;
  logic         oscIn = 1'b0;
  ccc_t         ccc = '0;
  logic         dataReady = 1'b0;
  logic         ibiAck, transitionBit, payloadTake, replyValid, async0Active, ibiRequest;
  logic         modeOn = 1'b0;
  xtime_reply_t reply;
  payload_t     payload;
  logic [7:0]   sub;
  logic [31:0]  replyQ[$], cntQ[$], got, ex;
  int           bad_count = 0, comparisons = 0, oscEdges = 0, e0, e1, seed = 32'h0000_b546;

  i3c_async0_timing_control u_dut (.ref_clk, .resetn, .oscIn, .ccc, .dataReady, .ibiAck,
    .transitionBit, .payloadTake, .reply, .replyValid, .async0Active, .ibiRequest, .payload);
  ibi_ctrl_model u_ctrl (.ref_clk, .ibiRequest, .payload, .ibiAck, .transitionBit,
    .payloadTake);

  // Reference clock and an oscillator of unrelated phase, with its edge count.
  initial forever #2.5 ref_clk = ~ref_clk;
  initial #7 forever #24 oscIn = ~oscIn;
  always @(posedge oscIn) oscEdges++;

  function automatic bit near(logic [15:0] a, logic [15:0] b);
    return (a >= b ? a - b : b - a) <= 1;
  endfunction

  task automatic check(string what, logic [31:0] exp, logic [31:0] seen, bit ok);
    comparisons++;
    if (!ok)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Takes the oldest note whenever a reply or a whole payload appears.
  always @(posedge ref_clk)
  begin
    if (replyValid === 1'b1)
    begin
      ex = replyQ.pop_front();
      check("reply", ex, reply, reply === ex);
    end
    if (payload.valid === 1'b1 && payloadTake)
    begin
      got = {payload.data, got[31:8]};
      if (payload.last === 1'b1)
      begin
        ex = cntQ.pop_front();
        check("counts", ex, got, near(got[15:0], ex[15:0]) && near(got[31:16], ex[31:16]));
      end
    end
  end

  task automatic query();
    @(negedge ref_clk);
    ccc.getTime = 1'b1;
    replyQ.push_back({8'h03, 6'h00, modeOn, 1'b0, 8'h09, 8'h05});
    @(negedge ref_clk);
    ccc.getTime = 1'b0;
  endtask

  task automatic setMode(logic [7:0] code);
    @(negedge ref_clk);
    ccc.setTime = 1'b1;
    ccc.subCmd = code;
    modeOn = (code == 8'hDF);
    @(negedge ref_clk);
    ccc.setTime = 1'b0;
    check("mode", modeOn, async0Active, async0Active === modeOn);
  endtask

  // A ready pulse that raises an interrupt only while mode 0 is on.
  task automatic idleCheck(logic expIbi);
    @(negedge ref_clk);
    dataReady = 1'b1;
    @(negedge ref_clk);
    dataReady = 1'b0;
    check("ready", expIbi, ibiRequest, ibiRequest === expIbi);
  endtask

  // One timed event; a wider pulse lands while the sequence runs and is dropped.
  task automatic timedEvent(int width);
    int n;
    @(negedge ref_clk);
    dataReady = 1'b1;
    @(posedge ref_clk);
    e0 = oscEdges;
    repeat (width) @(negedge ref_clk);
    dataReady = 1'b0;
    for (n = 0; n < 200 && ibiAck !== 1'b1; n++) @(posedge ref_clk);
    if (ibiAck !== 1'b1) check("ack wait", 1, 0, 1'b0);
    e1 = oscEdges;
    for (n = 0; n < 200 && transitionBit !== 1'b1; n++) @(posedge ref_clk);
    if (transitionBit !== 1'b1) check("tbit wait", 1, 0, 1'b0);
    cntQ.push_back({16'(oscEdges - e1), 16'(e1 - e0)});
    for (n = 0; n < 300 && !(payload.valid && payloadTake && payload.last); n++)
      @(posedge ref_clk);
    if (!(payload.valid && payloadTake && payload.last))
      check("payload wait", 1, 0, 1'b0);
  endtask

  task automatic finish_test();
    $display("comparisons %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence: mode off, timed events in mode 0, then leaving and aborting.
  initial
  begin
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    query();
    idleCheck(1'b0);
    $display("test mode off done");
    setMode(8'hDF);
    query();
    for (int i = 0; i < 6; i++)
      timedEvent(1 + i % 2);
    $display("test timed events done");
    sub = 8'($random(seed));
    if (sub == 8'hDF)
      sub = 8'h00;
    setMode(sub);
    idleCheck(1'b0);
    setMode(8'hDF);
    idleCheck(1'b1);
    setMode(sub);
    @(negedge ref_clk);
    check("abort", 0, ibiRequest, ibiRequest === 1'b0);
    repeat (100) @(negedge ref_clk);
    $display("test leave and abort done");
    finish_test();
  end

  // Watchdog against a hung handshake.
  initial
  begin
    #100us;
    bad_count++;
    finish_test();
  end
endmodule
